// ===== rtl/hub_cmd_map.svh
// Offsets, field positions, reset values and command codes of the hub
// command/status port. Included by the package and the port module only.
`ifndef HUB_CMD_MAP_SVH
`define HUB_CMD_MAP_SVH

// Register select on the external data bus
`define REG_COMMAND 2'h0
`define REG_DATA 2'h1
`define REG_STATUS 2'h2

// Command codes
`define CMD_CHIP_IDENTIFICATION_WORD 8'hFD
`define CMD_SET_VID_PID 8'hFB
`define CMD_LAST_ERROR 8'hFF

// Data byte counts per command
`define CNT_CHIP_IDENTIFICATION_WORD 3'h2
`define CNT_SET_VID_PID 3'h4
`define CNT_LAST_ERROR 3'h1

// Last transaction error byte fields
`define ERR_FLAG_BIT 4
`define ERR_CODE_MSB 3

// Status register bits
`define ST_BUSY_BIT 0
`define ST_BAD_CMD_BIT 1
`define ST_WRITE_BIT 2

// Suffix character upper bits
`define SUFFIX_CHAR_HI 12'h003

// Reset values
`define RST_LAST_ERROR 8'h00
`define RST_COMMAND 8'h00

// Interface clock
`define MCU_CLK_HZ 12000000

`endif

// ===== rtl/hub_cmd_pkg.sv
// Types shared by the hub command/status port files.
// Assumes hub_cmd_map.svh on the include path.
`include "hub_cmd_map.svh"

package hub_cmd_pkg;
  // Command sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } seq_state_e;

  typedef logic [3:0] fault_code_t;
  typedef logic [1:0] reg_sel_t;
endpackage

// ===== rtl/fault_code_encoder.sv
// Priority encoder turning packet fault indications into a 4-bit code.
// Assumes the packet engine presents all indications with i_pkt_done.
module fault_code_encoder
  import hub_cmd_pkg::*;
(
  input wire logic i_pid_seen,
  input wire logic [7:0] i_pid_byte,
  input wire logic i_unexpected,
  input wire logic i_setup_nonctrl,
  input wire logic i_token_crc,
  input wire logic i_data_crc,
  input wire logic i_timeout,
  input wire logic i_babble,
  input wire logic i_early_eop,
  input wire logic i_nak,
  input wire logic i_stall,
  input wire logic i_overflow,
  input wire logic i_iso_empty,
  input wire logic i_stuff_err,
  input wire logic i_sync_err,
  input wire logic i_bad_toggle,
  output hub_cmd_pkg::fault_code_t o_code
);
  // Defined packet identifiers of the low nibble
  function automatic logic pid_known(input logic [3:0] p);
    case (p)
      4'h1, 4'h9, 4'h5, 4'hD, 4'h3, 4'hB, 4'h2, 4'hA, 4'hE, 4'hC: pid_known = 1'b1;
      default: pid_known = 1'b0;
    endcase
  endfunction

  wire logic pid_bad_enc;
  wire logic pid_unknown;
  assign pid_bad_enc = i_pid_seen && (i_pid_byte[7:4] != ~i_pid_byte[3:0]);
  assign pid_unknown = i_pid_seen && !pid_bad_enc && !pid_known(i_pid_byte[3:0]);

  // Link faults first, then protocol outcomes
  always_comb begin
    if (i_sync_err) o_code = 4'hE; // [RULE12]
    else if (i_stuff_err) o_code = 4'hD; // [RULE12]
    else if (i_early_eop) o_code = 4'h8; // [RULE12]
    else if (pid_bad_enc) o_code = 4'h1; // [RULE10]
    else if (pid_unknown) o_code = 4'h2; // [RULE10]
    else if (i_token_crc) o_code = 4'h4; // [RULE12]
    else if (i_data_crc) o_code = 4'h5; // [RULE12]
    else if (i_babble) o_code = 4'h7; // [RULE12]
    else if (i_timeout) o_code = 4'h6; // [RULE12]
    else if (i_overflow) o_code = 4'hB; // [RULE15]
    else if (i_bad_toggle) o_code = 4'hF; // [RULE17]
    else if (i_unexpected || i_setup_nonctrl) o_code = 4'h3; // [RULE11]
    else if (i_stall) o_code = 4'hA; // [RULE14]
    else if (i_nak) o_code = 4'h9; // [RULE13]
    else if (i_iso_empty) o_code = 4'hC; // [RULE16]
    else o_code = 4'h0; // [RULE10]
  end
endmodule

// ===== rtl/hub_command_status_port.sv
// Hub command/status port: command, data and status registers seen by the
// keyboard microcontroller, chip identity, VID/PID set and last packet error.
// Assumes a single-cycle read or write strobe on i_clk from the core.
//
// How it works
// (RULE1) Core reaches the hub only via command, data, status registers.
// (RULE2) Interface clock is the 12 MHz PLL-derived microcontroller clock.
// (RULE3) Chip identity command FD returns low byte then high byte.
// (RULE4) Identity word: suffix digit bits 11..8, release bits 7..0.
// (RULE5) Suffix character code is 0x003 then the four suffix bits.
// (RULE6) Silicon release number is a constant raised per revision.
// (RULE7) Command FB takes VID low, VID high, PID low, PID high.
// (RULE8) Command FF returns failed flag bit 4, code bits 3..0.
// (RULE9) Failed flag refreshed on every packet transfer.
// (RULE10) Codes: 0 none, 1 PID encoding, 2 unknown PID.
// (RULE11) Code 3 for wrong packet kind or SETUP to non-control.
// (RULE12) Codes 4,5,6,7,8,D,E for CRC, timeout, babble, EOP, stuff, sync.
// (RULE13) Code 9 when a NAK was sent or received.
// (RULE14) Code A when a stall answered a halted endpoint.
// (RULE15) Code B when received data exceeds buffer space.
// (RULE16) Code C when an empty isochronous packet was sent.
// (RULE17) Code F and payload dropped on wrong data toggle.
// (RULE18) Data bytes move one per data access until the count ends.
`include "hub_cmd_map.svh"

module hub_command_status_port #(
  parameter logic [3:0] PART_SUFFIX_DIGIT = 4'h7, // Arbitrary value
  parameter logic [7:0] SILICON_RELEASE_NUMBER = 8'h2A, // Arbitrary value
  parameter logic [15:0] RST_VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] RST_PRODUCT_ID = 16'h5678 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input hub_cmd_pkg::reg_sel_t i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_pkt_done,
  input wire logic i_pid_seen,
  input wire logic [7:0] i_pid_byte,
  input wire logic i_unexpected,
  input wire logic i_setup_nonctrl,
  input wire logic i_token_crc,
  input wire logic i_data_crc,
  input wire logic i_timeout,
  input wire logic i_babble,
  input wire logic i_early_eop,
  input wire logic i_nak,
  input wire logic i_stall,
  input wire logic i_overflow,
  input wire logic i_iso_empty,
  input wire logic i_stuff_err,
  input wire logic i_sync_err,
  input wire logic i_bad_toggle,
  output logic o_discard_payload,
  output logic [15:0] o_vendor_id,
  output logic [15:0] o_product_id,
  output logic o_vidpid_update,
  output logic [15:0] o_suffix_char
);
  import hub_cmd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Identity

  // Fixed identity word, reserved top nibble zero
  wire logic [15:0] chip_identification_word;
  assign chip_identification_word = {4'h0, PART_SUFFIX_DIGIT, SILICON_RELEASE_NUMBER}; // [RULE4] [RULE6]
  // Suffix character for the product name string
  assign o_suffix_char = {`SUFFIX_CHAR_HI, PART_SUFFIX_DIGIT}; // [RULE5]

  //////////////////////////////////////////////////////////////////////////
  // Packet fault capture

  fault_code_t fault_code;
  logic [7:0] last_transaction_error_reg;
  logic [7:0] last_transaction_error_next;
  wire logic last_packet_failed_flag;
  wire fault_code_t transaction_fault_code;

  fault_code_encoder u_encoder (
    .i_pid_seen(i_pid_seen),
    .i_pid_byte(i_pid_byte),
    .i_unexpected(i_unexpected),
    .i_setup_nonctrl(i_setup_nonctrl),
    .i_token_crc(i_token_crc),
    .i_data_crc(i_data_crc),
    .i_timeout(i_timeout),
    .i_babble(i_babble),
    .i_early_eop(i_early_eop),
    .i_nak(i_nak),
    .i_stall(i_stall),
    .i_overflow(i_overflow),
    .i_iso_empty(i_iso_empty),
    .i_stuff_err(i_stuff_err),
    .i_sync_err(i_sync_err),
    .i_bad_toggle(i_bad_toggle),
    .o_code(fault_code)
  );

  // New byte on each packet, reserved bits zero
  assign last_transaction_error_next = i_pkt_done ?
    {3'h0, (fault_code != 4'h0), fault_code} : last_transaction_error_reg; // [RULE9] [RULE8]
  assign last_packet_failed_flag = last_transaction_error_reg[`ERR_FLAG_BIT];
  assign transaction_fault_code = last_transaction_error_reg[`ERR_CODE_MSB:0];
  // Payload dropped on a wrong toggle
  assign o_discard_payload = i_pkt_done && (fault_code == 4'hF); // [RULE17]

  // Error byte register
  always_ff @(posedge i_clk) begin
    if (i_rst) last_transaction_error_reg <= `RST_LAST_ERROR;
    else last_transaction_error_reg <= last_transaction_error_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Register decode

  wire logic cmd_wr;
  wire logic data_wr;
  wire logic data_rd;
  wire logic stat_rd;
  wire logic cmd_rd;
  // Only three addresses respond; others read zero
  assign cmd_wr = i_wr && (i_addr == `REG_COMMAND); // [RULE1]
  assign cmd_rd = i_rd && (i_addr == `REG_COMMAND); // [RULE1]
  assign data_wr = i_wr && (i_addr == `REG_DATA); // [RULE1]
  assign data_rd = i_rd && (i_addr == `REG_DATA); // [RULE1]
  assign stat_rd = i_rd && (i_addr == `REG_STATUS); // [RULE1]

  //////////////////////////////////////////////////////////////////////////
  // Command sequencer

  seq_state_e state_reg;
  seq_state_e state_next;
  logic [7:0] command_reg;
  logic [7:0] command_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [1:0] index_reg;
  logic [1:0] index_next;
  logic bad_cmd_reg;
  logic bad_cmd_next;
  logic [7:0] err_snap_reg;
  logic [7:0] err_snap_next;
  logic [7:0] byte_out;
  wire logic last_byte;
  wire logic read_step;
  wire logic write_step;

  assign read_step = (state_reg == ST_READ) && data_rd;
  assign write_step = (state_reg == ST_WRITE) && data_wr;
  assign last_byte = ({1'b0, index_reg} + 3'h1) == count_reg;

  // Next-state of the byte exchange
  always_comb begin
    state_next = state_reg;
    command_next = command_reg;
    count_next = count_reg;
    index_next = index_reg;
    bad_cmd_next = bad_cmd_reg;
    err_snap_next = err_snap_reg;
    if (cmd_wr) begin
      command_next = i_wdata;
      index_next = 2'h0;
      bad_cmd_next = 1'b0;
      case (i_wdata)
        `CMD_CHIP_IDENTIFICATION_WORD: begin
          state_next = ST_READ; // [RULE3]
          count_next = `CNT_CHIP_IDENTIFICATION_WORD;
        end
        `CMD_LAST_ERROR: begin
          state_next = ST_READ; // [RULE8]
          count_next = `CNT_LAST_ERROR;
          err_snap_next = last_transaction_error_reg;
        end
        `CMD_SET_VID_PID: begin
          state_next = ST_WRITE; // [RULE7]
          count_next = `CNT_SET_VID_PID;
        end
        default: begin
          state_next = ST_IDLE;
          count_next = 3'h0;
          bad_cmd_next = 1'b1;
        end
      endcase
    end else if (read_step || write_step) begin
      // One byte per data access, stop at the count
      index_next = index_reg + 2'h1; // [RULE18]
      if (last_byte) state_next = ST_IDLE; // [RULE18]
    end
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      command_reg <= `RST_COMMAND;
      count_reg <= 3'h0;
      index_reg <= 2'h0;
      bad_cmd_reg <= 1'b0;
      err_snap_reg <= `RST_LAST_ERROR;
    end else begin
      state_reg <= state_next;
      command_reg <= command_next;
      count_reg <= count_next;
      index_reg <= index_next;
      bad_cmd_reg <= bad_cmd_next;
      err_snap_reg <= err_snap_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // VID/PID capture

  logic [15:0] vendor_id_reg;
  logic [15:0] vendor_id_next;
  logic [15:0] product_id_reg;
  logic [15:0] product_id_next;
  logic vidpid_stage_reg;
  logic [7:0] stage_b0_reg;
  logic [7:0] stage_b1_reg;
  logic [7:0] stage_b2_reg;
  wire logic commit;

  // Fourth byte commits all four together
  assign commit = write_step && last_byte && (command_reg == `CMD_SET_VID_PID); // [RULE7]
  assign vendor_id_next = commit ? {stage_b1_reg, stage_b0_reg} : vendor_id_reg; // [RULE7]
  assign product_id_next = commit ? {i_wdata, stage_b2_reg} : product_id_reg; // [RULE7]

  // Staging of the first three bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage_b0_reg <= 8'h00;
      stage_b1_reg <= 8'h00;
      stage_b2_reg <= 8'h00;
    end else if (write_step) begin
      if (index_reg == 2'h0) stage_b0_reg <= i_wdata;
      if (index_reg == 2'h1) stage_b1_reg <= i_wdata;
      if (index_reg == 2'h2) stage_b2_reg <= i_wdata;
    end
  end

  // Descriptor identifiers and update pulse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vendor_id_reg <= RST_VENDOR_ID;
      product_id_reg <= RST_PRODUCT_ID;
      vidpid_stage_reg <= 1'b0;
    end else begin
      vendor_id_reg <= vendor_id_next;
      product_id_reg <= product_id_next;
      vidpid_stage_reg <= commit;
    end
  end

  assign o_vendor_id = vendor_id_reg;
  assign o_product_id = product_id_reg;
  assign o_vidpid_update = vidpid_stage_reg;

  //////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Byte selected by the current command and index
  always_comb begin
    byte_out = 8'h00;
    if (command_reg == `CMD_CHIP_IDENTIFICATION_WORD) begin
      byte_out = (index_reg == 2'h0) ? chip_identification_word[7:0] : chip_identification_word[15:8]; // [RULE3]
    end else if (command_reg == `CMD_LAST_ERROR) begin
      byte_out = err_snap_reg; // [RULE8]
    end
  end

  // Register readback mux
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd) begin
      case (i_addr)
        `REG_COMMAND: rdata_next = command_reg;
        `REG_DATA: rdata_next = read_step ? byte_out : 8'h00; // [RULE18]
        `REG_STATUS: rdata_next = {5'h00, (state_reg == ST_WRITE), bad_cmd_reg, (state_reg != ST_IDLE)};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data register on the microcontroller clock
  always_ff @(posedge i_clk) begin // [RULE2]
    if (i_rst) rdata_reg <= 8'h00;
    else rdata_reg <= rdata_next;
  end

  assign o_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Command exchange, packet capture and readback
  a_id_low_first: assert property (read_step && command_reg == `CMD_CHIP_IDENTIFICATION_WORD && index_reg == 2'h0 // [RULE3]
    |=> o_rdata == SILICON_RELEASE_NUMBER) else $error("chip_identification_word low byte wrong");
  a_id_high_second: assert property (read_step && command_reg == `CMD_CHIP_IDENTIFICATION_WORD && index_reg == 2'h1 // [RULE4]
    |=> o_rdata == {4'h0, PART_SUFFIX_DIGIT}) else $error("chip_identification_word high byte wrong");
  a_suffix_code: assert property (o_suffix_char[15:4] == 12'h003 // [RULE5]
    && o_suffix_char[3:0] == PART_SUFFIX_DIGIT) else $error("suffix character wrong");
  a_err_refresh: assert property (i_pkt_done |=> transaction_fault_code == $past(fault_code) // [RULE9]
    && last_packet_failed_flag == ($past(fault_code) != 4'h0) && last_transaction_error_reg[7:5] == 3'h0)
    else $error("error byte inconsistent");
  a_err_hold: assert property (!i_pkt_done |=> $stable(last_transaction_error_reg)) // [RULE9]
    else $error("error byte changed without packet");
  a_nak_code: assert property (i_pkt_done && i_nak && !i_pid_seen && fault_code == 4'h9 // [RULE13]
    |=> transaction_fault_code == 4'h9 && last_packet_failed_flag) else $error("nak not recorded");
  a_toggle_drop: assert property (i_pkt_done && i_bad_toggle && !i_pid_seen && !i_overflow && !i_timeout // [RULE17]
    && !i_babble && !i_data_crc && !i_token_crc && !i_early_eop && !i_stuff_err && !i_sync_err
    |-> o_discard_payload ##1 transaction_fault_code == 4'hF) else $error("toggle fault not handled");
  a_ff_byte: assert property ((cmd_wr && i_wdata == `CMD_LAST_ERROR) ##1 (!i_wr && !i_rd) // [RULE8]
    ##1 (data_rd && !i_wr) |=> o_rdata == $past(last_transaction_error_reg, 3))
    else $error("last error read wrong");
  a_vidpid_commit: assert property (commit |=> o_vidpid_update && o_product_id[15:8] == $past(i_wdata) // [RULE7]
    && state_reg == ST_IDLE) else $error("vid pid not committed");
  a_byte_count: assert property ((read_step || write_step) && last_byte && !cmd_wr // [RULE18]
    |=> state_reg == ST_IDLE) else $error("exchange overran its count");
  a_unmapped_zero: assert property (i_rd && i_addr == 2'h3 |=> o_rdata == 8'h00) // [RULE1]
    else $error("unmapped read not zero");
  a_cmd_readback: assert property (cmd_rd |=> o_rdata == $past(command_reg)) // [RULE1]
    else $error("command readback wrong");
  a_unknown_cmd: assert property (cmd_wr && i_wdata != `CMD_CHIP_IDENTIFICATION_WORD && i_wdata != `CMD_LAST_ERROR // [RULE18]
    && i_wdata != `CMD_SET_VID_PID |=> state_reg == ST_IDLE && bad_cmd_reg)
    else $error("unknown command accepted");
  a_data_ignored: assert property (data_rd && state_reg == ST_IDLE |=> o_rdata == 8'h00) // [RULE18]
    else $error("data read outside exchange");
  a_write_ignored: assert property (data_wr && state_reg != ST_WRITE // [RULE7]
    |=> $stable(vendor_id_reg) && $stable(product_id_reg)) else $error("stray write changed ids");

  // Main scenarios reached
  c_chip_identification_word: cover property ((cmd_wr && i_wdata == `CMD_CHIP_IDENTIFICATION_WORD) ##2 data_rd ##2 data_rd);
  c_vidpid: cover property (commit);
  c_last_error: cover property (i_pkt_done && fault_code != 4'h0 ##2 (cmd_wr && i_wdata == `CMD_LAST_ERROR));
  c_bad_cmd: cover property (!bad_cmd_reg ##1 bad_cmd_reg);
endmodule

// ===== sim/mcu_bus_model.sv
// Microcontroller model: issues command, data and status accesses.
// Assumes the bench calls its tasks; strobes change at falling edges.
module mcu_bus_model
  import hub_cmd_pkg::*;
(
  input wire logic i_clk,
  output hub_cmd_pkg::reg_sel_t o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    o_addr = 2'h3;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // One write strobe; released lines show inverted values
  task automatic wr(input reg_sel_t a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // One read strobe; byte taken at the falling edge that ends the strobe
  task automatic rd(input reg_sel_t a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
  // Identifier set: command then four bytes in order
  task automatic set_ids(input logic [15:0] vid, input logic [15:0] pid);
    wr(2'h0, 8'hFB);
    wr(2'h1, vid[7:0]);
    wr(2'h1, vid[15:8]);
    wr(2'h1, pid[7:0]);
    wr(2'h1, pid[15:8]);
  endtask
endmodule

// ===== sim/hub_command_status_port_tb_top.sv
// Self-checking bench of the hub command/status port.
// Assumes the microcontroller model and the package are compiled first.
module hub_command_status_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hub_cmd_pkg::*;
  localparam logic [3:0] SUFFIX = 4'h9; // Arbitrary value
  localparam logic [7:0] RELEASE = 8'h3C; // Arbitrary value
  localparam logic [15:0] VID0 = 16'hA1B2;
  localparam logic [15:0] PID0 = 16'hC3D4;
  typedef struct packed {
    logic ps;
    logic [7:0] pid;
    logic [13:0] f;
    logic [3:0] code;
  } row_s;
  logic i_clk, i_rst, wr, rd, pkt_done, pid_seen, discard, upd;
  reg_sel_t addr;
  logic [7:0] wdata, rdata, pid, d;
  logic [13:0] flt;
  logic [15:0] vid_o, pid_o, sfx;
  int n_errors = 0;
  int checks_done = 0;
  // Fault rows: bit 0 unexpected .. bit 13 toggle, then expected code
  row_s rows[20] = '{'{1'b0, 8'h00, 14'h0000, 4'h0}, '{1'b1, 8'hD2, 14'h0000, 4'h0},
    '{1'b1, 8'h00, 14'h0000, 4'h1}, '{1'b1, 8'hF0, 14'h0000, 4'h2},
    '{1'b0, 8'h00, 14'h0001, 4'h3}, '{1'b0, 8'h00, 14'h0002, 4'h3},
    '{1'b0, 8'h00, 14'h0004, 4'h4}, '{1'b0, 8'h00, 14'h0008, 4'h5},
    '{1'b0, 8'h00, 14'h0010, 4'h6}, '{1'b0, 8'h00, 14'h0020, 4'h7},
    '{1'b0, 8'h00, 14'h0040, 4'h8}, '{1'b0, 8'h00, 14'h0080, 4'h9},
    '{1'b0, 8'h00, 14'h0100, 4'hA}, '{1'b0, 8'h00, 14'h0200, 4'hB},
    '{1'b0, 8'h00, 14'h0400, 4'hC}, '{1'b0, 8'h00, 14'h0800, 4'hD},
    '{1'b0, 8'h00, 14'h1000, 4'hE}, '{1'b0, 8'h00, 14'h2000, 4'hF},
    '{1'b0, 8'h00, 14'h0000, 4'h0}, '{1'b0, 8'h00, 14'h1080, 4'hE}};
  ////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  mcu_bus_model i_mcu (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata));
  hub_command_status_port #(.PART_SUFFIX_DIGIT(SUFFIX), .SILICON_RELEASE_NUMBER(RELEASE),
    .RST_VENDOR_ID(VID0), .RST_PRODUCT_ID(PID0)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
    .o_rdata(rdata), .i_pkt_done(pkt_done), .i_pid_seen(pid_seen), .i_pid_byte(pid),
    .i_unexpected(flt[0]), .i_setup_nonctrl(flt[1]), .i_token_crc(flt[2]), .i_data_crc(flt[3]),
    .i_timeout(flt[4]), .i_babble(flt[5]), .i_early_eop(flt[6]), .i_nak(flt[7]),
    .i_stall(flt[8]), .i_overflow(flt[9]), .i_iso_empty(flt[10]), .i_stuff_err(flt[11]),
    .i_sync_err(flt[12]), .i_bad_toggle(flt[13]), .o_discard_payload(discard),
    .o_vendor_id(vid_o), .o_product_id(pid_o), .o_vidpid_update(upd), .o_suffix_char(sfx));
  ////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One packet transfer with the faults of a row
  task automatic pkt(input row_s r);
    @(negedge i_clk);
    pid_seen = r.ps;
    pid = r.pid;
    flt = r.f;
    pkt_done = 1'b1;
    #1;
    check("discard", {15'h0000, discard}, {15'h0000, r.code == 4'hF});
    @(negedge i_clk);
    pkt_done = 1'b0;
    flt = 14'h0000;
    pid_seen = 1'b0;
  endtask
  // Fetch the last error byte
  task automatic last_err(output logic [7:0] e);
    i_mcu.wr(2'h0, 8'hFF);
    i_mcu.rd(2'h1, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (4000) @(posedge i_clk);
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    i_rst = 1'b1;
    pkt_done = 1'b0;
    pid_seen = 1'b0;
    pid = 8'h00;
    flt = 14'h0000;
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    check("vid", vid_o, VID0);
    check("pid", pid_o, PID0);
    check("rdata", rdata, 8'h00);
    check("update", upd, 1'b0);
    check("suffix char", sfx, {12'h003, SUFFIX});
    last_err(d);
    check("err reset", d, 8'h00);
    // Identity: low byte then high byte
    i_mcu.wr(2'h0, 8'hFD);
    i_mcu.rd(2'h1, d);
    check("id low", d, RELEASE);
    i_mcu.rd(2'h1, d);
    check("id high", d, {4'h0, SUFFIX});
    // Ordinary fault rows
    foreach (rows[k]) begin
      pkt(rows[k]);
      last_err(d);
      check("err byte", d, {3'b000, rows[k].code != 4'h0, rows[k].code});
    end
    // New identifiers, pulse one cycle after the fourth byte
    i_mcu.set_ids(16'h5A01, 16'h7E02);
    check("update pulse", upd, 1'b1);
    check("vid new", vid_o, 16'h5A01);
    check("pid new", pid_o, 16'h7E02);
    @(negedge i_clk);
    check("update end", upd, 1'b0);
    // Aborted identifier set leaves values alone
    i_mcu.wr(2'h0, 8'hFB);
    i_mcu.wr(2'h1, 8'hAA);
    i_mcu.wr(2'h1, 8'hBB);
    i_mcu.rd(2'h2, d);
    check("status write", d, 8'h05);
    i_mcu.wr(2'h0, 8'hFD);
    i_mcu.rd(2'h1, d);
    check("id after abort", d, RELEASE);
    check("vid kept", vid_o, 16'h5A01);
    i_mcu.rd(2'h1, d);
    i_mcu.rd(2'h1, d);
    check("extra read", d, 8'h00);
    // Unknown command and unmapped select
    i_mcu.wr(2'h0, 8'h12);
    i_mcu.rd(2'h2, d);
    check("status unknown", d, 8'h02);
    i_mcu.rd(2'h1, d);
    check("no exchange", d, 8'h00);
    i_mcu.rd(2'h0, d);
    check("command read", d, 8'h12);
    i_mcu.wr(2'h1, 8'h66);
    check("stray write", vid_o, 16'h5A01);
    i_mcu.wr(2'h3, 8'h55);
    i_mcu.rd(2'h3, d);
    check("unmapped", d, 8'h00);
    // Reset in mid-run restores defaults
    pkt(rows[11]);
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    check("vid reset", vid_o, VID0);
    check("pid reset", pid_o, PID0);
    i_mcu.rd(2'h2, d);
    check("status reset", d, 8'h00);
    last_err(d);
    check("err after reset", d, 8'h00);
    end_sim();
  end
endmodule
